// ### design/sysref_status_and_chip_mode_regs.sv
// Sysref capture status, sync mode select and chip operating mode registers.
`default_nettype none

module sysref_status_and_chip_mode_regs #(
  parameter int SAMPLE_WIDTH = sysref_mode_pkg::SAMPLE_WIDTH_DEFAULT,
  parameter int DIVIDE       = sysref_mode_pkg::DIVIDE_DEFAULT
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [11:0]             reg_addr,
  input  wire logic                    reg_write,
  input  wire logic [7:0]              reg_write_data,
  input  wire logic                    reg_read,
  output logic      [7:0]              reg_read_data,
  output logic                         reg_read_valid,
  input  wire logic                    sysref_captured,
  input  wire logic [3:0]              sysref_phase_measured,
  input  wire logic                    count_clear,
  input  wire logic [SAMPLE_WIDTH-1:0] sample_in,
  input  wire logic                    sample_in_valid,
  output logic      [SAMPLE_WIDTH-1:0] sample_out,
  output logic                         sample_out_valid,
  output logic                         sample_out_timestamp,
  output logic                         link_down,
  output logic                         divider_tick,
  output logic                         monitor_sysref_enable,
  output logic                         q_output_enable,
  output logic                         downconverter_first,
  output logic                         downconverter_second,
  output logic                         downconverter_third,
  output logic                         downconverter_fourth,
  output logic      [5:0]              decimation_factor,
  output logic                         decimation_bypass
);
  import sysref_mode_pkg::*;

  // A sample word needs at least one bit; anything less is refused when built.
  if (SAMPLE_WIDTH < 1) begin : g_bad_width
    $error("sysref_status_and_chip_mode_regs: SAMPLE_WIDTH must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [3:0] phase_status;
  logic [7:0] capture_count;
  logic       sync_mode;
  logic [7:0] app_control;
  logic [3:0] decim_code;
  logic [3:0] next_phase_status;
  logic [7:0] next_capture_count;
  logic       next_sync_mode;
  logic [7:0] next_app_control;
  logic [3:0] next_decim_code;
  logic [7:0] next_read_data;
  logic       timestamp_mode;

  assign timestamp_mode = (sync_mode == SYNC_MODE_TIMESTAMP);

  // Capture status and the control writes. The phase code is passed through as measured,
  // so every half-cycle step from in phase to seven and a half cycles is kept exact.
  always_comb begin
    next_phase_status = phase_status;
    next_capture_count = capture_count;
    next_sync_mode = sync_mode;
    next_app_control = app_control;
    next_decim_code = decim_code;
    if (sysref_captured) begin
      next_phase_status = sysref_phase_measured;
      next_capture_count = capture_count + 8'h01;
    end
    if (count_clear) begin
      next_capture_count = COUNT_RESET;
    end
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_SYNC_MODE: begin
          next_sync_mode = reg_write_data[SYNC_MODE_BIT];
        end
        ADDR_APP_MODE: begin
          // Bit 4 is reserved and read only; it stays zero.
          next_app_control = {reg_write_data[APP_RESERVED_MSB:APP_RESERVED_LSB],
                              reg_write_data[Q_IGNORE_BIT], 1'b0,
                              reg_write_data[APP_MODE_MSB:APP_MODE_LSB]};
        end
        ADDR_DECIMATION: begin
          next_decim_code = reg_write_data[DECIM_MSB:DECIM_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // The count is read without synchronising to captures; software is expected to stop
  // capturing first, so no snapshot logic is spent here.
  always_comb begin
    next_read_data = READ_UNMAPPED;
    unique case (reg_addr)
      ADDR_PHASE_STATUS: next_read_data = {4'h0, phase_status};
      ADDR_CAPTURE_COUNT: next_read_data = capture_count;
      ADDR_SYNC_MODE: next_read_data = {7'h00, sync_mode};
      ADDR_APP_MODE: next_read_data = app_control;
      ADDR_DECIMATION: next_read_data = {4'h0, decim_code};
      default: next_read_data = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_status <= PHASE_RESET;
      capture_count <= COUNT_RESET;
      sync_mode <= SYNC_MODE_RESET[SYNC_MODE_BIT];
      app_control <= APP_MODE_RESET;
      decim_code <= DECIMATION_RESET[3:0];
      reg_read_data <= READ_UNMAPPED;
      reg_read_valid <= 1'b0;
    end else begin
      phase_status <= next_phase_status;
      capture_count <= next_capture_count;
      sync_mode <= next_sync_mode;
      app_control <= next_app_control;
      decim_code <= next_decim_code;
      reg_read_data <= reg_read ? next_read_data : reg_read_data;
      reg_read_valid <= reg_read;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divider alignment; the divider only sees captures in synchronization mode.
  logic phase_moved;

  divider_align #(
    .DIVIDE (DIVIDE)
  ) u_divider (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .sysref_event (sysref_captured),
    .sync_jesd    (!timestamp_mode),
    .divider_tick (divider_tick),
    .phase_moved  (phase_moved)
  );

  // Link down is a one-cycle request to the link logic to restart its alignment.
  assign link_down = phase_moved;

  // The signal monitor follows the reference only in synchronization mode.
  assign monitor_sysref_enable = !timestamp_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Timestamp marking. A capture that falls between valid samples is held and placed on
  // the next valid sample; several captures that fall in one gap between samples share a single mark.
  logic                    mark_pending;
  logic                    next_mark_pending;
  logic                    mark_now;
  logic [SAMPLE_WIDTH-1:0] next_sample_out;

  always_comb begin
    mark_now = mark_pending || (timestamp_mode && sysref_captured);
    next_mark_pending = mark_now && !sample_in_valid;
    next_sample_out = sample_in_valid ? sample_in : sample_out;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mark_pending <= 1'b0;
      sample_out <= '0;
      sample_out_valid <= 1'b0;
      sample_out_timestamp <= 1'b0;
    end else begin
      mark_pending <= next_mark_pending;
      sample_out <= next_sample_out;
      sample_out_valid <= sample_in_valid;
      sample_out_timestamp <= sample_in_valid && mark_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decodes from the control registers.
  app_mode_type app_mode;

  assign app_mode = app_mode_type'(app_control[APP_MODE_MSB:APP_MODE_LSB]);
  assign q_output_enable = !app_control[Q_IGNORE_BIT];

  // Unlisted application codes enable no downconverter, like full bandwidth.
  always_comb begin
    downconverter_first = 1'b0;
    downconverter_second = 1'b0;
    downconverter_third = 1'b0;
    downconverter_fourth = 1'b0;
    unique case (app_mode)
      APP_ONE_DOWNCONVERTER: begin
        downconverter_first = 1'b1;
      end
      APP_TWO_DOWNCONVERTERS: begin
        downconverter_first = 1'b1;
        downconverter_second = 1'b1;
      end
      APP_FOUR_DOWNCONVERTERS: begin
        downconverter_first = 1'b1;
        downconverter_second = 1'b1;
        downconverter_third = 1'b1;
        downconverter_fourth = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign decimation_factor = decimation_ratio(decim_code);
  assign decimation_bypass = (decimation_ratio(decim_code) == 6'd1);

endmodule : sysref_status_and_chip_mode_regs
`default_nettype wire

// ### design/sysref_mode_pkg.sv
// Package of offsets, field positions, reset values and decodes for the sysref and mode registers.
`default_nettype none
package sysref_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets on the serial control port's internal register access.
  localparam logic [11:0] ADDR_PHASE_STATUS = 12'h129;
  localparam logic [11:0] ADDR_CAPTURE_COUNT = 12'h12a;
  localparam logic [11:0] ADDR_SYNC_MODE = 12'h1ff;
  localparam logic [11:0] ADDR_APP_MODE = 12'h200;
  localparam logic [11:0] ADDR_DECIMATION = 12'h201;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SYNC_MODE_BIT = 0;
  localparam int Q_IGNORE_BIT = 5;
  localparam int APP_RESERVED_LSB = 6;
  localparam int APP_RESERVED_MSB = 7;
  localparam int APP_MODE_LSB = 0;
  localparam int APP_MODE_MSB = 3;
  localparam int DECIM_LSB = 0;
  localparam int DECIM_MSB = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [3:0] PHASE_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SYNC_MODE_RESET = 8'h00;
  localparam logic [7:0] APP_MODE_RESET = 8'h00;
  localparam logic [7:0] DECIMATION_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Default divide ratio of the internal clock divider in ref_clk cycles.
  localparam int DIVIDE_DEFAULT = 8;
  // Default sample word width.
  localparam int SAMPLE_WIDTH_DEFAULT = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Encodings.
  localparam logic SYNC_MODE_JESD = 1'b1;
  localparam logic SYNC_MODE_TIMESTAMP = 1'b0;

  typedef enum logic [3:0] {
    APP_FULL_BANDWIDTH = 4'h0,
    APP_ONE_DOWNCONVERTER = 4'h1,
    APP_TWO_DOWNCONVERTERS = 4'h2,
    APP_FOUR_DOWNCONVERTERS = 4'h3
  } app_mode_type;

  // Decimation code to ratio; zero means an unlisted code, code 0000 is ratio 1 (bypass).
  function automatic logic [5:0] decimation_ratio(input logic [3:0] code);
    logic [5:0] ratio;
    ratio = 6'h00;
    unique case (code)
      4'h0: ratio = 6'd1;
      4'h1: ratio = 6'd2;
      4'h8: ratio = 6'd3;
      4'h2: ratio = 6'd4;
      4'h5: ratio = 6'd5;
      4'h9: ratio = 6'd6;
      4'h3: ratio = 6'd8;
      4'h6: ratio = 6'd10;
      4'ha: ratio = 6'd12;
      4'h7: ratio = 6'd15;
      4'h4: ratio = 6'd16;
      4'hd: ratio = 6'd20;
      4'hb: ratio = 6'd24;
      4'he: ratio = 6'd30;
      4'hf: ratio = 6'd40;
      4'hc: ratio = 6'd48;
    endcase
    return ratio;
  endfunction : decimation_ratio

endpackage : sysref_mode_pkg
`default_nettype wire

// ### design/divider_align.sv
// Internal clock divider that a reference capture realigns in synchronization mode.
`default_nettype none
module divider_align #(
  parameter int DIVIDE = sysref_mode_pkg::DIVIDE_DEFAULT
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic sysref_event,
  input  wire logic sync_jesd,
  output logic      divider_tick,
  output logic      phase_moved
);
  import sysref_mode_pkg::*;

  localparam int CW = (DIVIDE > 2) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  // A divider of one never leaves zero, so such a build is refused outright.
  if (DIVIDE < 2) begin : g_bad_divide
    $error("divider_align: DIVIDE must be at least 2");
  end

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_phase_moved;

  ////////////////////////////////////////////////////////////////////////////////
  // A capture in synchronization mode forces the divider back to zero. Only a capture on
  // the last count leaves the phase as it was, so a periodic reference aligned to the
  // divider keeps the link up; any other capture moves the phase and drops the link.
  always_comb begin
    next_phase_moved = 1'b0;
    if (count == LAST) begin
      next_count = '0;
    end else begin
      next_count = count + CW'(1);
    end
    if (sysref_event && sync_jesd) begin
      next_count = '0;
      next_phase_moved = (count != LAST);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      phase_moved <= 1'b0;
    end else begin
      count <= next_count;
      phase_moved <= next_phase_moved;
    end
  end

  assign divider_tick = (count == '0);

endmodule : divider_align
`default_nettype wire

// ### test/sysref_mode_props.sv
// Port-level timing checker for the sysref status and chip mode block.
`default_nettype none
module sysref_mode_props
  import sysref_mode_pkg::*;
#(
  parameter int DIVIDE = DIVIDE_DEFAULT
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_write_data,
  input wire logic        reg_read,
  input wire logic        reg_read_valid,
  input wire logic        sysref_captured,
  input wire logic        sample_in_valid,
  input wire logic        sample_out_timestamp,
  input wire logic        link_down,
  input wire logic        divider_tick,
  input wire logic        monitor_sysref_enable,
  input wire logic        q_output_enable,
  input wire logic [5:0]  decimation_factor,
  input wire logic        decimation_bypass
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since the divider last sat at zero; while the tick is low this is its count.
  int   tick_age;
  logic at_last;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_age <= 0;
    end else begin
      tick_age <= divider_tick ? 1 : tick_age + 1;
    end
  end
  // A capture on the last count lands where the divider was heading anyway.
  assign at_last = !divider_tick && (tick_age == DIVIDE - 1);
  ////////////////////////////////////////
  // A capture splits into two kinds by the current sync mode.
  sequence s_sync_capture;
    sysref_captured && monitor_sysref_enable;
  endsequence
  sequence s_stamp_capture;
    sysref_captured && !monitor_sysref_enable;
  endsequence
  a_read_answer: assert property (reg_read |=> reg_read_valid)
    else $error("read strobe not answered");
  a_read_quiet: assert property (!reg_read |=> !reg_read_valid)
    else $error("read valid without a read");
  a_divider_realign: assert property (s_sync_capture |=> divider_tick)
    else $error("divider not realigned by capture");
  a_link_drop: assert property (s_sync_capture ##0 !at_last |=> link_down)
    else $error("link not dropped on phase move");
  a_link_hold: assert property (s_sync_capture ##0 at_last |=> !link_down)
    else $error("link dropped although divider phase kept");
  a_link_cause: assert property (link_down |-> $past(sysref_captured && monitor_sysref_enable))
    else $error("link dropped without a sync capture");
  a_divider_free: assert property (s_stamp_capture ##0 divider_tick |=> !divider_tick)
    else $error("divider disturbed in timestamp mode");
  a_stamp_mark: assert property (s_stamp_capture ##0 sample_in_valid |=> sample_out_timestamp)
    else $error("coinciding sample not marked");
  a_q_select: assert property (reg_write && reg_addr == ADDR_APP_MODE
    |=> q_output_enable == !$past(reg_write_data[Q_IGNORE_BIT]))
    else $error("quadrature enable does not follow write");
  a_bypass_ratio: assert property (decimation_bypass == (decimation_factor == 6'h01))
    else $error("bypass disagrees with ratio");
endmodule : sysref_mode_props

bind sysref_status_and_chip_mode_regs sysref_mode_props #(.DIVIDE(DIVIDE)) props_i (.ref_clk,
  .reset, .reg_addr,
  .reg_write, .reg_write_data, .reg_read, .reg_read_valid, .sysref_captured, .sample_in_valid,
  .sample_out_timestamp, .link_down, .divider_tick, .monitor_sysref_enable, .q_output_enable,
  .decimation_factor, .decimation_bypass);
`default_nettype wire

// ### test/sysref_link_receiver.sv
// Link receiver model that tallies words, timestamp marks and link drops.
`default_nettype none
module sysref_link_receiver (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic sample_out_valid,
  input  wire logic sample_out_timestamp,
  input  wire logic link_down,
  output int        words,
  output int        marks,
  output int        drops
);
  timeunit 1ns;
  timeprecision 1ns;
  // A mark only counts on a valid word, as a real receiver would see it.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      words <= 0;
      marks <= 0;
      drops <= 0;
    end else begin
      words <= words + int'(sample_out_valid);
      marks <= marks + int'(sample_out_valid && sample_out_timestamp);
      drops <= drops + int'(link_down);
    end
  end
endmodule : sysref_link_receiver
`default_nettype wire

// ### test/tb_sysref_status_and_chip_mode_regs.sv
// Testbench for the sysref status and chip mode registers.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_sysref_status_and_chip_mode_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import sysref_mode_pkg::*;
  logic        ref_clk, reset, reg_write, reg_read, sysref_captured, count_clear;
  logic        reg_read_valid, sample_in_valid, sample_out_valid, sample_out_timestamp;
  logic        link_down, divider_tick, monitor_sysref_enable, q_output_enable, decimation_bypass;
  logic [11:0] reg_addr;
  logic [7:0]  reg_write_data, reg_read_data;
  logic [3:0]  sysref_phase_measured, dc;
  logic [15:0] sample_in, sample_out;
  logic [5:0]  decimation_factor;
  int          words, marks, drops, n_fail, checks_done;
  int          ratio [16] = '{1, 2, 4, 8, 16, 5, 10, 15, 3, 6, 12, 24, 48, 20, 30, 40};
  logic [3:0]  dcx [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
  sysref_status_and_chip_mode_regs #(.SAMPLE_WIDTH(16), .DIVIDE(8))
    sysref_status_and_chip_mode_regs_i (.ref_clk, .reset, .reg_addr, .reg_write, .reg_write_data,
    .reg_read, .reg_read_data, .reg_read_valid, .sysref_captured, .sysref_phase_measured,
    .count_clear, .sample_in, .sample_in_valid, .sample_out, .sample_out_valid,
    .sample_out_timestamp, .link_down, .divider_tick, .monitor_sysref_enable, .q_output_enable,
    .downconverter_first(dc[0]), .downconverter_second(dc[1]), .downconverter_third(dc[2]),
    .downconverter_fourth(dc[3]), .decimation_factor, .decimation_bypass);
  sysref_link_receiver sysref_link_receiver_i (.ref_clk, .reset, .sample_out_valid,
    .sample_out_timestamp, .link_down, .words, .marks, .drops);
  ////////////////////////////////////////
  // Register port strobes last exactly one cycle, as the port takes them.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_write_data = d;
    reg_write = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_read = 1'b0;
    `CHK("read_valid", 1'b1, reg_read_valid)
    `CHK("read_data", e, reg_read_data)
  endtask : rd
  // One capture with a coinciding valid sample; reads happen only between captures.
  task automatic cap(input logic [3:0] ph, input logic clr);
    @(posedge ref_clk);
    #1;
    sysref_captured = 1'b1;
    sysref_phase_measured = ph;
    sample_in_valid = 1'b1;
    sample_in = {12'h000, ph};
    count_clear = clr;
    @(posedge ref_clk);
    #1;
    sysref_captured = 1'b0;
    sample_in_valid = 1'b0;
    count_clear = 1'b0;
  endtask : cap
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Hang guard, well beyond the roughly 630 cycles the run needs.
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    {reset, reg_write, reg_read, sysref_captured, count_clear, sample_in_valid} = 6'h20;
    {reg_addr, reg_write_data, sysref_phase_measured, sample_in} = '0;
    repeat (16) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    foreach (dcx[i]) rd(i < 3 ? 12'h129 + 12'(i) : 12'h0ff, 8'h00);
    `CHK("q_enable", 1'b1, q_output_enable)
    `CHK("bypass", 1'b1, decimation_bypass)
    wr(ADDR_CAPTURE_COUNT, 8'hff);
    rd(ADDR_CAPTURE_COUNT, 8'h00);
    wr(ADDR_SYNC_MODE, 8'hff);
    rd(ADDR_SYNC_MODE, 8'h01);
    wr(ADDR_SYNC_MODE, 8'h00);
    wr(ADDR_APP_MODE, 8'hff);
    rd(ADDR_APP_MODE, 8'hef);
    `CHK("dc_unlisted", 4'h0, dc)
    `CHK("q_enable", 1'b0, q_output_enable)
    wr(ADDR_DECIMATION, 8'hff);
    rd(ADDR_DECIMATION, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_APP_MODE, 8'(i));
      `CHK("dc", dcx[i], dc)
    end
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_DECIMATION, 8'(i));
      `CHK("ratio", 6'(ratio[i]), decimation_factor)
      `CHK("bypass", i == 0, decimation_bypass)
    end
    // 257 timestamp-mode captures wrap the count back to one.
    for (int i = 0; i < 257; i++) begin
      cap(4'(i + 15), 1'b0);
      if (i == 2) rd(ADDR_CAPTURE_COUNT, 8'h03);
    end
    rd(ADDR_CAPTURE_COUNT, 8'h01);
    rd(ADDR_PHASE_STATUS, 8'h0f);
    cap(4'h2, 1'b1);
    rd(ADDR_CAPTURE_COUNT, 8'h00);
    rd(ADDR_PHASE_STATUS, 8'h02);
    `CHK("marks", 258, marks)
    `CHK("drops_ts", 0, drops)
    wr(ADDR_SYNC_MODE, 8'h01);
    `CHK("monitor", 1'b1, monitor_sysref_enable)
    for (int k = 0; k < 16 && !divider_tick; k++) begin
      @(posedge ref_clk);
      #1;
    end
    cap(4'h1, 1'b0);
    `CHK("tick_sync", 1'b1, divider_tick)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("drops_sync", 1, drops)
    // One divide period later the capture meets the divider on its last count: no drop.
    repeat (4) @(posedge ref_clk);
    cap(4'h7, 1'b0);
    `CHK("tick_aligned", 1'b1, divider_tick)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("drops_aligned", 1, drops)
    `CHK("marks_sync", 258, marks)
    `CHK("words", 260, words)
    `CHK("sample_out", 16'h0007, sample_out)
    report_and_stop();
  end
endmodule : tb_sysref_status_and_chip_mode_regs
`default_nettype wire
